// *** hdl/ctc_card_fsm.v ***
// What this block does
// - Power-up reset places the card in the idle waiting state.
// - Idle moves to uid_stage_one on REQA or WUPA; other data keeps idle.
// - HLTA from active or authenticated makes halt the waiting state; only WUPA or rf_reset leaves.
// - uid_stage_one resolves first three UID bytes via anticollision or level 1 select.
// - Level 1 select enters uid_stage_two and answers SAK 04h.
// - READ of page 00h in either UID stage goes straight to active.
// - Unexpected frames in UID stages fall back to the current waiting state.
// - uid_stage_two resolves remaining four UID bytes via level 2 anticollision.
// - Level 2 select selects the card uniquely and answers SAK 00h.
// - Active accepts 16-byte READ, 4-byte WRITE, legacy write, or authentication start.
// - Successful authentication enters the authenticated state.
// - HLTA in active moves the card to halt.
// - Other commands in active fall back to the current waiting state.
// - Authenticated state additionally allows access to protected pages.
// - Received standard frames carry a 16-bit CRC, answers none; bit count and sequence are checked.
// - Each frame starts with exactly one start bit.
// - Each byte is followed by an odd parity bit.
// - Bytes go least significant bit first, lowest address byte first.
// - No frame exceeds 163 bits; the 164th bit marks an error.
// - Memory is 48 pages of 32 bits, addressed by page.
// - Erased cells read 0; written cells read the written data, lock bits once set stay 1.
// - Manufacturer, lock and OTP areas are reserved; the rest is user storage.
// - Writes to the lock page OR data into lock bits.
// - New lock settings apply only after the next REQA or WUPA.
`include "ctc_consts.vh"

module ctc_card_fsm (
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire        clk_en,
  input  wire        rf_reset,
  input  wire        rx_valid,
  input  wire        rx_bit,
  input  wire        rx_end,
  input  wire        auth_ok,
  input  wire        auth_fail,
  output reg         tx_valid,
  output reg         tx_bit,
  output reg         tx_end,
  input  wire        tx_ready,
  output wire        auth_start,
  output reg  [5:0]  card_state
);

  // ========================================================================
  // States.
  // ========================================================================
  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_UID1 = 6'b000010;
  localparam [5:0] ST_UID2 = 6'b000100;
  localparam [5:0] ST_ACT  = 6'b001000;
  localparam [5:0] ST_HALT = 6'b010000;
  localparam [5:0] ST_AUTH = 6'b100000;

  localparam [2:0] TX_IDLE  = 3'b001;
  localparam [2:0] TX_START = 3'b010;
  localparam [2:0] TX_DATA  = 3'b100;

  // ========================================================================
  // Memory and lock state.
  // ========================================================================
  // page memory
  reg  [31:0] mem_q [0:47];
  reg  [15:0] lock_live_q;
  reg         halted_q;
  reg  [5:0]  state_q;
  integer     i;

  // ========================================================================
  // Receive deserialiser: start bit, 8 data bits, odd parity per byte.
  // ========================================================================
  reg  [7:0]  rx_buf_q [0:17];
  reg  [4:0]  rx_nbytes_q;
  reg  [3:0]  rx_bitpos_q;
  reg  [7:0]  rx_shift_q;
  reg         rx_par_q;
  reg         rx_started_q;
  reg         rx_err_q;
  reg  [7:0]  rx_bitcnt_q;
  reg  [15:0] crc_q;
  reg  [15:0] crc_d;
  integer     k;

  // Reflected CRC over one byte.
  always @* begin
    crc_d = crc_q ^ {8'h00, rx_shift_q};
    for (k = 0; k < 8; k = k + 1) begin
      crc_d = crc_d[0] ? ((crc_d >> 1) ^ `CTC_CRC_POLY) : (crc_d >> 1);
    end
  end

  wire frame_done = clk_en && rx_end && rx_started_q;

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      rx_nbytes_q  <= 5'd0;
      rx_bitpos_q  <= 4'd0;
      rx_shift_q   <= 8'h00;
      rx_par_q     <= 1'b0;
      rx_started_q <= 1'b0;
      rx_err_q     <= 1'b0;
      rx_bitcnt_q  <= 8'd0;
      crc_q        <= `CTC_CRC_INIT;
    end else if (clk_en) begin
      if (rx_end) begin
        rx_started_q <= 1'b0;
        rx_nbytes_q  <= 5'd0;
        rx_bitpos_q  <= 4'd0;
        rx_err_q     <= 1'b0;
        rx_bitcnt_q  <= 8'd0;
        crc_q        <= `CTC_CRC_INIT;
      end else if (rx_valid) begin
        rx_bitcnt_q <= rx_bitcnt_q + 8'd1;
        if (rx_bitcnt_q >= `CTC_MAX_FRAME_BITS - 8'd1)
          rx_err_q <= 1'b1;
        if (!rx_started_q) begin
          rx_started_q <= 1'b1;
          if (!rx_bit)
            rx_err_q <= 1'b1;
        end else if (rx_bitpos_q < 4'd8) begin
          rx_shift_q  <= {rx_bit, rx_shift_q[7:1]};
          rx_bitpos_q <= rx_bitpos_q + 4'd1;
        end else begin
          if ((^rx_shift_q) == rx_bit)
            rx_err_q <= 1'b1;
          if (rx_nbytes_q < `CTC_MAX_BYTES) begin
            rx_buf_q[rx_nbytes_q] <= rx_shift_q;
            rx_nbytes_q           <= rx_nbytes_q + 5'd1;
          end else begin
            rx_err_q <= 1'b1;
          end
          crc_q       <= crc_d;
          rx_bitpos_q <= 4'd0;
        end
      end
    end
  end

  // ========================================================================
  // Frame classification.
  // ========================================================================
  wire [7:0] cmd  = rx_buf_q[0];
  wire [7:0] arg  = rx_buf_q[1];
  wire       crc_ok  = (crc_q == `CTC_CRC_RESIDUE) && (rx_bitpos_q == 4'd0);
  wire       rx_bad  = rx_err_q;
  // Short frames hold 7 bits and no parity; their command sits in the shift register.
  wire [6:0] short_cmd = rx_shift_q[7:1];
  wire       is_reqa = frame_done && !rx_bad && (rx_nbytes_q == 5'd0) && (rx_bitpos_q == 4'd7)
                       && (short_cmd == `CTC_CMD_REQA);
  wire       is_wupa = frame_done && !rx_bad && (rx_nbytes_q == 5'd0) && (rx_bitpos_q == 4'd7)
                       && (short_cmd == `CTC_CMD_WUPA);
  wire       good    = frame_done && !rx_bad && crc_ok;
  wire       is_anti = frame_done && !rx_bad && (rx_bitpos_q == 4'd0) && (rx_nbytes_q >= 5'd2)
                       && (arg != `CTC_NVB_FULL);
  wire       is_sel  = good && (rx_nbytes_q == 5'd9) && (arg == `CTC_NVB_FULL);
  wire       is_read = good && (rx_nbytes_q == 5'd4) && (cmd == `CTC_CMD_READ);
  wire       is_wr   = good && (rx_nbytes_q == 5'd8) && (cmd == `CTC_CMD_WRITE);
  wire       is_cwr  = good && (rx_nbytes_q == 5'd8) && (cmd == `CTC_CMD_CWRITE);
  wire       is_auth = good && (cmd == `CTC_CMD_AUTH);
  wire       is_hlta = good && (rx_nbytes_q == 5'd4) && (cmd == `CTC_CMD_HLTA);
  wire [5:0] page    = arg[5:0];
  wire       page_ok = (arg < {2'b00, `CTC_PAGES});

  wire       prot_ok = (state_q == ST_AUTH) || (page < `CTC_PROT_FROM);
  // Lock bit index for pages 3..15 sits at bit (page) of the lock halfword.
  wire       pg_lock = (page >= `CTC_PAGE_OTP) && (page < `CTC_PROT_FROM) && lock_live_q[page[3:0]];
  wire       wr_ok   = page_ok && prot_ok && !pg_lock && (page >= `CTC_PAGE_LOCK) && (page <= `CTC_PAGE_LAST);

  assign auth_start = is_auth && ((state_q == ST_ACT) || (state_q == ST_AUTH));

  wire [5:0] wait_state = halted_q ? ST_HALT : ST_IDLE;

  // ========================================================================
  // Answer builder.
  // ========================================================================
  reg  [7:0] tx_buf_q [0:17];
  reg  [4:0] tx_len_q;
  reg  [4:0] tx_idx_q;
  reg  [3:0] tx_pos_q;
  reg  [2:0] tx_st_q;
  reg        tx_go;
  reg  [4:0] tx_go_len;
  wire [7:0] cur_byte = tx_buf_q[tx_idx_q];

  // ========================================================================
  // Command interpreter.
  // ========================================================================
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q     <= ST_IDLE;
      halted_q    <= 1'b0;
      lock_live_q <= 16'h0000;
      tx_go       <= 1'b0;
      tx_go_len   <= 5'd0;
      for (i = 0; i < 48; i = i + 1)
        mem_q[i] <= `CTC_ERASED_PAGE;
    end else if (clk_en) begin
      tx_go <= 1'b0;
      if (rf_reset) begin
        state_q  <= ST_IDLE;
        halted_q <= 1'b0;
      end else if (frame_done) begin
        if (is_reqa || is_wupa)
          lock_live_q <= {mem_q[`CTC_PAGE_LOCK][31:24], mem_q[`CTC_PAGE_LOCK][23:16]};
        case (state_q)
          ST_IDLE: begin
            if (is_reqa || is_wupa) begin
              state_q     <= ST_UID1;
              tx_buf_q[0] <= `CTC_ATQA_LO;
              tx_buf_q[1] <= `CTC_ATQA_HI;
              tx_go_len   <= 5'd2;
              tx_go       <= 1'b1;
            end
          end
          ST_HALT: begin
            if (is_wupa) begin
              state_q     <= ST_UID1;
              tx_buf_q[0] <= `CTC_ATQA_LO;
              tx_buf_q[1] <= `CTC_ATQA_HI;
              tx_go_len   <= 5'd2;
              tx_go       <= 1'b1;
            end
          end
          ST_UID1, ST_UID2: begin
            if (is_read && (page == `CTC_PAGE_UID0)) begin
              state_q <= ST_ACT;
              for (i = 0; i < 16; i = i + 1)
                tx_buf_q[i] <= mem_q[i/4][8*(i%4) +: 8];
              tx_go_len <= 5'd16;
              tx_go     <= 1'b1;
            end else if (is_sel && (cmd == ((state_q == ST_UID1) ? `CTC_CMD_SEL_CL1 : `CTC_CMD_SEL_CL2))) begin
              state_q     <= (state_q == ST_UID1) ? ST_UID2 : ST_ACT;
              tx_buf_q[0] <= (state_q == ST_UID1) ? `CTC_SAK_CL1 : `CTC_SAK_CL2;
              tx_go_len   <= 5'd1;
              tx_go       <= 1'b1;
            end else if (is_anti && (cmd == ((state_q == ST_UID1) ? `CTC_CMD_SEL_CL1 : `CTC_CMD_SEL_CL2))) begin
              if (state_q == ST_UID1) begin
                tx_buf_q[0] <= `CTC_CASCADE_TAG;
                tx_buf_q[1] <= mem_q[`CTC_PAGE_UID0][7:0];
                tx_buf_q[2] <= mem_q[`CTC_PAGE_UID0][15:8];
                tx_buf_q[3] <= mem_q[`CTC_PAGE_UID0][23:16];
                tx_buf_q[4] <= mem_q[`CTC_PAGE_UID0][31:24];
              end else begin
                tx_buf_q[0] <= mem_q[`CTC_PAGE_UID1][7:0];
                tx_buf_q[1] <= mem_q[`CTC_PAGE_UID1][15:8];
                tx_buf_q[2] <= mem_q[`CTC_PAGE_UID1][23:16];
                tx_buf_q[3] <= mem_q[`CTC_PAGE_UID1][31:24];
                tx_buf_q[4] <= mem_q[`CTC_PAGE_LOCK][7:0];
              end
              tx_go_len <= 5'd5;
              tx_go     <= 1'b1;
            end else begin
              state_q <= wait_state;
            end
          end
          ST_ACT, ST_AUTH: begin
            if (is_read && page_ok && prot_ok) begin
              for (i = 0; i < 16; i = i + 1)
                tx_buf_q[i] <= mem_q[(page + i/4) % 48][8*(i%4) +: 8];
              tx_go_len <= 5'd16;
              tx_go     <= 1'b1;
            end else if ((is_wr || is_cwr) && wr_ok) begin
              if (page == `CTC_PAGE_LOCK)
                mem_q[page][31:16] <= mem_q[page][31:16] | {rx_buf_q[5], rx_buf_q[4]};
              else
                mem_q[page] <= {rx_buf_q[5], rx_buf_q[4], rx_buf_q[3], rx_buf_q[2]};
            end else if (is_auth) begin
              state_q <= state_q;
            end else if (is_hlta) begin
              state_q  <= ST_HALT;
              halted_q <= 1'b1;
            end else begin
              state_q <= wait_state;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end else if (auth_ok && (state_q == ST_ACT)) begin
        state_q <= ST_AUTH;
      end else if (auth_fail && ((state_q == ST_ACT) || (state_q == ST_AUTH))) begin
        state_q <= wait_state;
      end
    end
  end

  // ========================================================================
  // Transmit serialiser: start bit, bytes LSB first, odd parity each.
  // ========================================================================
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      tx_st_q    <= TX_IDLE;
      tx_len_q   <= 5'd0;
      tx_idx_q   <= 5'd0;
      tx_pos_q   <= 4'd0;
      tx_valid   <= 1'b0;
      tx_bit     <= 1'b0;
      tx_end     <= 1'b0;
      card_state <= ST_IDLE;
    end else if (clk_en) begin
      card_state <= state_q;
      case (tx_st_q)
        TX_IDLE: begin
          tx_valid <= 1'b0;
          if (tx_go) begin
            tx_len_q <= tx_go_len;
            tx_idx_q <= 5'd0;
            tx_pos_q <= 4'd0;
            tx_st_q  <= TX_START;
          end
        end
        TX_START: begin
          tx_valid <= 1'b1;
          tx_bit   <= (tx_valid && tx_ready) ? tx_buf_q[0][0] : 1'b1;
          if (tx_valid && tx_ready)
            tx_st_q <= TX_DATA;
        end
        TX_DATA: begin
          if (tx_ready && tx_end) begin
            tx_valid <= 1'b0;
            tx_end   <= 1'b0;
            tx_st_q  <= TX_IDLE;
          end else if (tx_ready && (tx_pos_q == 4'd8)) begin
            tx_pos_q <= 4'd0;
            tx_idx_q <= tx_idx_q + 5'd1;
            tx_bit   <= tx_buf_q[tx_idx_q + 5'd1][0];
          end else if (tx_ready) begin
            tx_pos_q <= tx_pos_q + 4'd1;
            tx_bit   <= (tx_pos_q == 4'd7) ? ~(^cur_byte) : cur_byte[tx_pos_q[2:0] + 3'd1];
            tx_end   <= (tx_pos_q == 4'd7) && (tx_idx_q + 5'd1 == tx_len_q);
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

endmodule // ctc_card_fsm

// *** hdl/ctc_consts.vh ***
`ifndef CTC_CONSTS_VH
`define CTC_CONSTS_VH
// ==========================================================================
// Command codes (first byte of a received frame, or the 7 bits of a short frame) and the full NVB (second byte).
// ==========================================================================
`define CTC_CMD_REQA      8'h26
`define CTC_CMD_WUPA      8'h52
`define CTC_CMD_SEL_CL1   8'h93
`define CTC_CMD_SEL_CL2   8'h95
`define CTC_CMD_READ      8'h30
`define CTC_CMD_WRITE     8'hA2
`define CTC_CMD_CWRITE    8'hA0
`define CTC_CMD_HLTA      8'h50
`define CTC_CMD_AUTH      8'h1A
`define CTC_NVB_FULL      8'h70
// ==========================================================================
// Answer values.
// ==========================================================================
`define CTC_SAK_CL1       8'h04
`define CTC_SAK_CL2       8'h00
`define CTC_ATQA_LO       8'h44
`define CTC_ATQA_HI       8'h00
`define CTC_CASCADE_TAG   8'h88
// ==========================================================================
// Frame integrity.
// ==========================================================================
`define CTC_MAX_FRAME_BITS 8'd164
`define CTC_MAX_BYTES     5'd18
`define CTC_CRC_INIT      16'h6363
`define CTC_CRC_POLY      16'h8408
`define CTC_CRC_RESIDUE   16'h0000
// ==========================================================================
// Memory layout.
// ==========================================================================
`define CTC_PAGES         6'd48
`define CTC_PAGE_UID0     6'h00
`define CTC_PAGE_UID1     6'h01
`define CTC_PAGE_LOCK     6'h02
`define CTC_PAGE_OTP      6'h03
`define CTC_PAGE_USER_LO  6'h04
`define CTC_PAGE_AUTH0    6'h2A
`define CTC_PAGE_LAST     6'h2F
`define CTC_PROT_FROM     6'h10
`define CTC_ERASED_PAGE   32'h00000000
`endif

// *** sim/ctc_card_fsm_asserts.sv ***
module ctc_card_fsm_asserts (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       clk_en,
  input wire logic       rf_reset,
  input wire logic       rx_valid,
  input wire logic       rx_bit,
  input wire logic       rx_end,
  input wire logic       auth_ok,
  input wire logic       auth_fail,
  input wire logic       tx_valid,
  input wire logic       tx_bit,
  input wire logic       tx_end,
  input wire logic       tx_ready,
  input wire logic       auth_start,
  input wire logic [5:0] card_state
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // State sequencing.
  // ==========================================================================
  reset_idle_a: assert property ($rose(reset_n) |-> card_state == 6'h01 && !tx_valid)
    else $error("card not idle and quiet after reset");
  state_onehot_a: assert property ($onehot(card_state))
    else $error("card state not one-hot");
  idle_exit_a: assert property (card_state == 6'h01 |=> card_state inside {6'h01, 6'h02})
    else $error("idle left to a wrong state");
  halt_exit_a: assert property (card_state == 6'h10 && !rf_reset && !$past(rf_reset)
    |=> card_state inside {6'h10, 6'h02})
    else $error("halt left without wake-up");
  rf_reset_idle_a: assert property (rf_reset && clk_en ##1 clk_en |=> card_state == 6'h01)
    else $error("field reset did not return to idle");
  stage_two_entry_a: assert property ($rose(card_state[2]) |-> $past(card_state[1]) && $past(rx_end, 2))
    else $error("second UID stage entered from wrong state");
  active_entry_a: assert property ($rose(card_state[3]) |-> $past(card_state[1] | card_state[2])
    && $past(rx_end, 2))
    else $error("active entered from wrong state");
  auth_entry_a: assert property ($rose(card_state[5]) |-> $past(card_state[3]) && $past(auth_ok, 2))
    else $error("authenticated entered without success");
  freeze_a: assert property (!clk_en |=> $stable(card_state))
    else $error("state moved with clock enable low");
  // ==========================================================================
  // Answer framing.
  // ==========================================================================
  answer_start_a: assert property ($rose(tx_valid) |-> tx_bit && $past(rx_end, 3))
    else $error("answer start bit wrong or late");
  bit_stands_a: assert property (tx_valid && !tx_ready && clk_en |=> tx_valid && $stable(tx_bit))
    else $error("answer bit changed while stalled");
  end_in_frame_a: assert property (tx_end |-> tx_valid)
    else $error("frame end outside answer");
  cover property (card_state == 6'h20);
  cover property ($rose(card_state[4]));
  cover property (tx_valid && !tx_ready);
endmodule // ctc_card_fsm_asserts

bind ctc_card_fsm ctc_card_fsm_asserts u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
  .rf_reset(rf_reset), .rx_valid(rx_valid), .rx_bit(rx_bit), .rx_end(rx_end), .auth_ok(auth_ok),
  .auth_fail(auth_fail), .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_end(tx_end), .tx_ready(tx_ready),
  .auth_start(auth_start), .card_state(card_state));

// *** sim/ctc_reader_model.sv ***
`include "ctc_consts.vh"
module ctc_reader_model (
  input  wire logic clk_sys,
  input  wire logic slow,
  input  wire logic tx_valid,
  input  wire logic tx_bit,
  input  wire logic tx_end,
  output logic      rx_valid,
  output logic      rx_bit,
  output logic      rx_end,
  output logic      tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic q[$];
  logic rbits[$];
  logic done;
  initial begin
    rx_valid = 1'b0;
    rx_bit   = 1'b0;
    rx_end   = 1'b0;
    tx_ready = 1'b1;
    done     = 1'b0;
  end
  // ==========================================================================
  // Answer collection, with stalls when slow is set.
  // ==========================================================================
  always @(posedge clk_sys) tx_ready <= #1 slow ? ~tx_ready : 1'b1;
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) begin
      rbits.push_back(tx_bit);
      if (tx_end) done <= 1'b1;
    end
  end
  // ==========================================================================
  // Frame building.
  // ==========================================================================
  // reflected CRC step.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) x = x[0] ? ((x >> 1) ^ `CTC_CRC_POLY) : (x >> 1);
    return x;
  endfunction
  task automatic put_byte(input logic [7:0] b, input logic flip);
    for (int k = 0; k < 8; k++) q.push_back(b[k]);
    q.push_back(~^b ^ flip);
  endtask
  // one start bit, short frames well below the length limit.
  task automatic send(input logic [55:0] d, input logic [3:0] n, input logic [1:0] bad);
    logic [15:0] c;
    c = `CTC_CRC_INIT;
    q.delete();
    rbits.delete();
    done = 1'b0;
    q.push_back(1'b1);
    if (n == 4'd0) begin
      for (int k = 0; k < 7; k++) q.push_back(d[k]);
    end else begin
      for (int i = 0; i < n; i++) begin
        put_byte(d[8*i +: 8], bad == 2'd2 && i == 0);
        c = crc_step(c, d[8*i +: 8]);
      end
      c[0] = c[0] ^ (bad == 2'd1);
      put_byte(c[7:0], 1'b0);
      put_byte(c[15:8], 1'b0);
    end
    foreach (q[k]) begin
      @(posedge clk_sys);
      #1 rx_valid = 1'b1;
      rx_bit = q[k];
    end
    @(posedge clk_sys);
    #1 rx_valid = 1'b0;
    rx_bit = ~rx_bit;
    rx_end = 1'b1;
    @(posedge clk_sys);
    #1 rx_end = 1'b0;
  endtask
endmodule // ctc_reader_model

// *** sim/ctc_card_fsm_tb.sv ***
module ctc_card_fsm_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [55:0] d;
    logic [3:0]  n;
    logic [5:0]  st;
    logic [1:0]  ro;
    logic [4:0]  ri;
    logic [7:0]  rb;
  } ctc_row_t;
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b0;
  logic       clk_en = 1'b1;
  logic       rf_reset = 1'b0;
  logic       auth_ok = 1'b0;
  logic       auth_fail = 1'b0;
  logic       slow = 1'b0;
  logic       auth_seen = 1'b0;
  logic       rx_valid, rx_bit, rx_end, tx_valid, tx_bit, tx_end, tx_ready, auth_start;
  logic [5:0] card_state;
  int         n_mismatch = 0;
  int         tests_run = 0;
  int         cyc = 0;
  // Rows: frame bytes (first byte lowest), byte count (0 is a short frame), state after, answer kind
  // (0 none, 1 checked, 2 not looked at), answer byte index and value.
  ctc_row_t rows [0:22] = '{
    '{56'h26, 4'd0, 6'h02, 2'd1, 5'd0, 8'h44}, '{56'h2093, 4'd2, 6'h02, 2'd1, 5'd0, 8'h88},
    '{56'h88000000887093, 4'd7, 6'h04, 2'd1, 5'd0, 8'h04}, '{56'h2095, 4'd2, 6'h04, 2'd1, 5'd0, 8'h00},
    '{56'h00000000007095, 4'd7, 6'h08, 2'd1, 5'd0, 8'h00}, '{56'h0050, 4'd2, 6'h10, 2'd0, 5'd0, 8'h00},
    '{56'h26, 4'd0, 6'h10, 2'd0, 5'd0, 8'h00}, '{56'h52, 4'd0, 6'h02, 2'd1, 5'd0, 8'h44},
    '{56'h0030, 4'd2, 6'h08, 2'd1, 5'd0, 8'h00}, '{56'h0077, 4'd2, 6'h10, 2'd0, 5'd0, 8'h00},
    '{56'h52, 4'd0, 6'h02, 2'd1, 5'd0, 8'h44}, '{56'h0050, 4'd2, 6'h10, 2'd0, 5'd0, 8'h00},
    '{56'h52, 4'd0, 6'h02, 2'd1, 5'd0, 8'h44}, '{56'h88000000887093, 4'd7, 6'h04, 2'd1, 5'd0, 8'h04},
    '{56'h0030, 4'd2, 6'h08, 2'd1, 5'd0, 8'h00}, '{56'h4433221105A2, 4'd6, 6'h08, 2'd2, 5'd0, 8'h00},
    '{56'h0530, 4'd2, 6'h08, 2'd1, 5'd0, 8'h11}, '{56'h00F0000002A2, 4'd6, 6'h08, 2'd2, 5'd0, 8'h00},
    '{56'h000F000002A2, 4'd6, 6'h08, 2'd2, 5'd0, 8'h00}, '{56'h0230, 4'd2, 6'h08, 2'd1, 5'd2, 8'hFF},
    '{56'h8877665506A0, 4'd6, 6'h08, 2'd2, 5'd0, 8'h00}, '{56'h0630, 4'd2, 6'h08, 2'd1, 5'd1, 8'h66},
    '{56'h001A, 4'd2, 6'h08, 2'd2, 5'd0, 8'h00}};
  ctc_row_t sel_idle = '{56'h88000000887093, 4'd7, 6'h01, 2'd0, 5'd0, 8'h00};

  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (auth_start === 1'b1) auth_seen <= 1'b1;

  ctc_card_fsm DUT (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .rf_reset(rf_reset),
    .rx_valid(rx_valid), .rx_bit(rx_bit), .rx_end(rx_end), .auth_ok(auth_ok), .auth_fail(auth_fail),
    .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_end(tx_end), .tx_ready(tx_ready), .auth_start(auth_start),
    .card_state(card_state));
  ctc_reader_model rdr (.clk_sys(clk_sys), .slow(slow), .tx_valid(tx_valid), .tx_bit(tx_bit),
    .tx_end(tx_end), .rx_valid(rx_valid), .rx_bit(rx_bit), .rx_end(rx_end), .tx_ready(tx_ready));

  // ==========================================================================
  // Checking helpers.
  // ==========================================================================
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s: saw %0h wanted %0h", $time, m, seen, exp);
    end
  endtask
  function automatic logic [7:0] rbyte(input int i);
    for (int k = 0; k < 8; k++) rbyte[k] = rdr.rbits[1 + 9*i + k];
  endfunction
  task automatic run_row(input ctc_row_t r, input logic [1:0] bad);
    rdr.send(r.d, r.n, bad);
    for (int i = 0; i < 700 && rdr.done !== 1'b1; i++) @(posedge clk_sys);
    #1;
    check(card_state, r.st, "state after frame");
    if (r.ro != 2'd2) check(rdr.done, r.ro[0], "answer presence");
    if (r.ro == 2'd1) begin
      check(rdr.rbits[0], 1'b1, "answer start bit");
      check(^{rbyte(0), rdr.rbits[9]}, 1'b1, "answer parity");
      check(rbyte(r.ri), r.rb, "answer byte");
    end
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    check(card_state, 6'h01, "idle after reset");
    foreach (rows[i]) begin
      slow = i % 2;
      run_row(rows[i], 2'd0);
    end
    check(auth_seen, 1'b1, "authentication start");
    @(posedge clk_sys);
    #1 auth_ok = 1'b1;
    @(posedge clk_sys);
    #1 auth_ok = 1'b0;
    @(posedge clk_sys);
    #1 check(card_state, 6'h20, "authenticated");
    run_row('{56'h1030, 4'd2, 6'h20, 2'd1, 5'd0, 8'h00}, 2'd0);
    run_row('{56'h0050, 4'd2, 6'h10, 2'd0, 5'd0, 8'h00}, 2'd0);
    @(posedge clk_sys);
    #1 rf_reset = 1'b1;
    @(posedge clk_sys);
    #1 rf_reset = 1'b0;
    @(posedge clk_sys);
    #1 check(card_state, 6'h01, "field reset");
    run_row('{56'h0077, 4'd2, 6'h01, 2'd0, 5'd0, 8'h00}, 2'd0);
    run_row(rows[0], 2'd0);
    run_row(sel_idle, 2'd1);
    run_row(rows[0], 2'd0);
    run_row(sel_idle, 2'd2);
    run_row(rows[0], 2'd0);
    run_row('{56'h0030, 4'd2, 6'h08, 2'd1, 5'd0, 8'h00}, 2'd0);
    run_row('{56'h1030, 4'd2, 6'h01, 2'd0, 5'd0, 8'h00}, 2'd0);
    run_row(rows[0], 2'd0);
    clk_en = 1'b0;
    rf_reset = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 check(card_state, 6'h02, "frozen state");
    clk_en = 1'b1;
    rf_reset = 1'b0;
    @(posedge clk_sys);
    #1 reset_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    check(card_state, 6'h01, "idle after second reset");
    check(tx_valid, 1'b0, "quiet after second reset");
    print_verdict();
  end
endmodule // ctc_card_fsm_tb
